// ===== inc/dpf_regs.svh
// register offsets, field limits, codes and timing for the drive supervisor
// assumes a 40 MHz control clock and an 8-bit byte address on the bus
`ifndef DPF_REGS_SVH
`define DPF_REGS_SVH
// ==========================================================
// register byte offsets
`define A_CTRL   8'h00
`define A_FAND   8'h04
`define A_OHD    8'h08
`define A_TEMP   8'h0C
`define A_FSPD   8'h10
`define A_STAT   8'h14
`define A_CLR    8'h18
// ==========================================================
// reset values and limits
`define OHD_RST  9'h001
`define OHD_MIN  9'h001
`define OHD_MAX  9'h12C
`define FAND_MAX 10'h258
`define FSPD_MAX 14'h2710
// ==========================================================
// thresholds (ohm, degrees C) and relay function code
`define R_TRIP   16'h0532
`define R_RESET  16'h0226
`define HS_THR   8'h5A
`define RLY_FN   7'h3B
// ==========================================================
// selector encodings
`define EXT_DEC  2'h0
`define EXT_CST  2'h1
`define EXT_KEEP 2'h2
`define OH_OFF   2'h0
`define OH_DEC   2'h1
`define FAN_RUN  2'h0
`define FAN_HOT  2'h2
// ==========================================================
// keypad fault codes; ground and external values are arbitrary
`define FC_NONE  8'h00
`define FC_GF    8'h3C
`define FC_EXT   8'h3D
`define FC_OH    8'h2E
// ==========================================================
// bus responses and timing
`define R_OK     2'h0
`define R_ERR    2'h2
`define CLK_HZ   40000000
`define SEC_S    1
`define SEC_CYC  (`CLK_HZ * `SEC_S)
`endif

// ===== inc/dpf_pkg.sv
// types shared by the drive protection and fire mode supervisor
// assumes the constants of dpf_regs.svh
package dpf_pkg;
  // fire mode states, one-hot
  typedef enum logic [2:0] {
    F_OFF   = 3'b001,
    F_ON    = 3'b010,
    F_LATCH = 3'b100
  } fire_t;
  // control word, low 23 bits of the control register
  typedef struct packed {
    logic [6:0] relay_fn;
    logic       fire_rev;
    logic [1:0] spd_src;
    logic       fire_nc;
    logic       fire_exit;
    logic       fire_en;
    logic [1:0] oh_sel;
    logic       big;
    logic [1:0] fan_mode;
    logic       safe_cst;
    logic       ext_run;
    logic [1:0] ext_sel;
    logic       gf_en;
  } cfg_t;
  // terminal inputs
  typedef struct packed {
    logic ext;
    logic safe;
    logic fire;
    logic lock;
  } pins_t;
  // measurements from the same clock domain
  typedef struct packed {
    logic [15:0] leak;
    logic [15:0] rated;
    logic [15:0] rt;
    logic        open;
    logic [7:0]  temp;
  } meas_t;
  // whole module state
  typedef struct packed {
    cfg_t        cfg;
    logic [9:0]  fan_dly;
    logic [8:0]  oh_dly;
    logic [7:0]  reach;
    logic [7:0]  ret;
    logic [13:0] spd;
    pins_t       s1;
    pins_t       s2;
    logic [25:0] sec;
    logic        tick;
    logic [10:0] fan_cnt;
    logic [8:0]  oh_cnt;
    fire_t       fire;
    logic        gf_f;
    logic        oh_f;
    logic        ext_f;
    logic        dec;
    logic        coast;
    logic        fault;
    logic [7:0]  code;
    logic        fan;
    logic        relay;
    logic        fa;
    logic        frev;
    logic        lock;
    logic        swf;
    logic        awrdy;
    logic        wrdy;
    logic        aw_h;
    logic        w_h;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } st_t;
endpackage

// ===== core/drive_protection_fire_mode_supervisor.sv
// drive protection, cooling fan, temperature relay and fire mode supervisor
// assumes terminal pins are asynchronous, measurements share i_clk
//
// What this block does
// R1: leakage above half rated current with protection on: ground code, coast, fault
// R2: external fault input reacts by selector: decelerate, coast or keep running
// R3: external fault checked always from power up, or only while running
// R4: safety stop input stops by decelerating or coasting per selector
// R5: fan mode 0 runs with drive, stops after stop exceeds off-delay
// R6: fan mode 1 keeps the fan on permanently from power up
// R7: fan mode 2 runs above heatsink threshold, stops when cool or delay ends
// R8: large models have fan control disabled, fan simply runs
// R9: overheat selector: 0 disabled, 1 decelerate, 2 coast
// R10: thermistor above 1330 ohm for set delay trips with overheat code
// R11: overheat fault may be cleared only below 550 ohm
// R12: an unconnected thermistor reports the overheat code
// R13: relay function 59 closes once inverter temperature exceeds reached level
// R14: return level capped at reached level; relay opens at or below it
// R15: fire trigger overrides run and speed, shows fire, stops the motor only on ground fault
// R16: fire mode suppresses the listed software fault codes
// R17: fire plus lock input ignores other inputs and refuses parameter writes
// R18: fire exit either needs power cycle or follows trigger removal
// R19: fire trigger polarity bit selects normally open or normally closed
// R20: operator disables fire mode before changing trigger polarity
// R21: fire speed source: fixed percentage up to 100.00, PID, or 4-20 mA
// R22: fire mode direction setting gives forward or reverse
// R23: overheat delay restarts when resistance falls back to trip level
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "dpf_regs.svh"
module drive_protection_fire_mode_supervisor
  import dpf_pkg::*;
#(
  parameter int unsigned SEC_CYC = `SEC_CYC
)(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // axi4-lite write address and data
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // axi4-lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // axi4-lite read
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // terminals, measurements, drive state
  input  wire pins_t       i_pins,
  input  wire meas_t       i_meas,
  input  wire logic        i_running,
  input  wire logic        i_sw_vld,
  input  wire logic [7:0]  i_sw_code,
  // stop requests, fault and relay contacts
  output logic             o_stop_dec,
  output logic             o_stop_coast,
  output logic             o_fault,
  output logic [7:0]       o_code,
  output logic             o_fan_on,
  output logic             o_temp_relay,
  output logic             o_sw_fault,
  // fire mode override
  output logic             o_fire_active,
  output logic             o_fire_rev,
  output logic [1:0]       o_fire_src,
  output logic [13:0]      o_fire_spd,
  output logic             o_di_ignore,
  output logic             o_param_lock
);
  st_t         st;
  st_t         next_st;
  logic        trig;
  logic        fa;
  logic        clr;
  logic        rhot;
  logic        hs_hot;
  logic        ev;
  logic        safe;
  logic [7:0]  retc;
  logic [31:0] img;

  // ==========================================================
  // helpers
  // byte-lane merge of a write into the old register image
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // software faults that fire mode hides
  function automatic logic supp(input logic [7:0] c);
    case (c)
      8'h04, 8'h05, 8'h06, 8'h07, 8'h19: return 1'b1;
      8'h1A, 8'h1C, 8'h2E, 8'h31, 8'h3A: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    clr     = 1'b0;
    img     = 32'h0000_0000;
    retc    = 8'h00;
    // pins pass two flops; s1 feeds only s2
    next_st.s1 = i_pins;
    next_st.s2 = st.s1;
    // one second enable; delays count whole ticks
    next_st.tick = 1'b0;
    if (st.sec == 26'(SEC_CYC - 1)) begin
      next_st.sec  = 26'h000_0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.sec = st.sec + 26'h000_0001;
    end

    // fire mode; polarity bit is expected to change only while disabled
    trig = st.cfg.fire_en & (st.s2.fire ^ st.cfg.fire_nc); // R19 R20
    case (st.fire)
      F_OFF: if (trig) next_st.fire = st.cfg.fire_exit ? F_ON : F_LATCH; // R18
      F_ON:  if (!trig) next_st.fire = F_OFF; // R18
      F_LATCH: next_st.fire = F_LATCH; // R18
      default: next_st.fire = F_OFF;
    endcase
    fa = (next_st.fire != F_OFF); // R15
    next_st.lock = fa & st.s2.lock; // R17

    // bus: retire answers the master has taken
    if (st.bvalid && i_bready) next_st.bvalid = 1'b0;
    if (st.rvalid && i_rready) next_st.rvalid = 1'b0;
    // address and data are caught in either order
    if (i_awvalid && st.awrdy) begin
      next_st.aw_h   = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && st.wrdy) begin
      next_st.w_h   = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    // write once both halves are in and no response is pending
    if (next_st.aw_h && next_st.w_h && !next_st.bvalid) begin
      next_st.aw_h   = 1'b0;
      next_st.w_h    = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `R_OK;
      if (next_st.lock) next_st.bresp = `R_ERR; // R17
      else begin
        case (next_st.awaddr)
          `A_CTRL: begin
            img = mrg({9'h000, st.cfg}, next_st.wdata, next_st.wstrb);
            next_st.cfg = cfg_t'(img[22:0]);
          end
          `A_FAND: begin
            img = mrg({22'h0, st.fan_dly}, next_st.wdata, next_st.wstrb);
            next_st.fan_dly = (img[31:10] != 22'h0 || img[9:0] > `FAND_MAX) ?
                              `FAND_MAX : img[9:0];
          end
          `A_OHD: begin
            img = mrg({23'h0, st.oh_dly}, next_st.wdata, next_st.wstrb);
            if (img[31:9] != 23'h0 || img[8:0] > `OHD_MAX) next_st.oh_dly = `OHD_MAX;
            else if (img[8:0] < `OHD_MIN) next_st.oh_dly = `OHD_MIN;
            else next_st.oh_dly = img[8:0];
          end
          `A_TEMP: begin
            img = mrg({16'h0, st.ret, st.reach}, next_st.wdata, next_st.wstrb);
            next_st.reach = img[7:0];
            next_st.ret   = img[15:8];
          end
          `A_FSPD: begin
            img = mrg({18'h0, st.spd}, next_st.wdata, next_st.wstrb);
            next_st.spd = (img[31:14] != 18'h0 || img[13:0] > `FSPD_MAX) ?
                          `FSPD_MAX : img[13:0]; // R21
          end
          `A_CLR: clr = next_st.wdata[0] & next_st.wstrb[0];
          default: next_st.bresp = `R_ERR;
        endcase
      end
    end
    // read answers one cycle after the address is taken
    if (i_arvalid && st.arrdy) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `R_OK;
      case (i_araddr)
        `A_CTRL: next_st.rdata = {9'h000, st.cfg};
        `A_FAND: next_st.rdata = {22'h0, st.fan_dly};
        `A_OHD:  next_st.rdata = {23'h0, st.oh_dly};
        `A_TEMP: next_st.rdata = {16'h0, st.ret, st.reach};
        `A_FSPD: next_st.rdata = {18'h0, st.spd};
        `A_STAT: next_st.rdata = {14'h0, st.ext_f, st.gf_f, st.oh_f, st.lock,
                                  st.fa, st.relay, st.fan, st.dec, st.coast,
                                  st.fault, st.code};
        `A_CLR:  next_st.rdata = 32'h0000_0000;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `R_ERR;
        end
      endcase
    end
    next_st.awrdy = !next_st.aw_h;
    next_st.wrdy  = !next_st.w_h;
    next_st.arrdy = !next_st.rvalid;

    // ground fault; a present condition wins over a clear
    if (clr) next_st.gf_f = 1'b0;
    if (st.cfg.gf_en && {i_meas.leak, 1'b0} > {1'b0, i_meas.rated}) next_st.gf_f = 1'b1; // R1

    // external fault, gated by detection timing
    ev = st.s2.ext & !next_st.lock & (!st.cfg.ext_run | i_running); // R3
    if (clr) next_st.ext_f = 1'b0;
    if (ev) next_st.ext_f = 1'b1; // R2
    safe = st.s2.safe & !next_st.lock; // R4

    // motor thermistor: delay restarts whenever resistance falls back
    rhot = i_meas.rt > `R_TRIP;
    if (!rhot) next_st.oh_cnt = 9'h000; // R23
    else if (st.tick && st.oh_cnt < st.oh_dly) next_st.oh_cnt = st.oh_cnt + 9'h001; // R10
    if (clr && i_meas.rt < `R_RESET && !i_meas.open) next_st.oh_f = 1'b0; // R11
    if (st.cfg.oh_sel != `OH_OFF && !fa &&
        (i_meas.open || (rhot && st.oh_cnt >= st.oh_dly)))
      next_st.oh_f = 1'b1; // R9 R10 R12 R16

    // cooling fan
    hs_hot = i_meas.temp > `HS_THR;
    if (st.cfg.big) begin
      next_st.fan     = 1'b1; // R8
      next_st.fan_cnt = 11'h000;
    end else begin
      case (st.cfg.fan_mode)
        `FAN_RUN: begin
          if (i_running) begin
            next_st.fan     = 1'b1; // R5
            next_st.fan_cnt = 11'h000;
          end else begin
            if (st.tick && st.fan_cnt <= {1'b0, st.fan_dly})
              next_st.fan_cnt = st.fan_cnt + 11'h001;
            if (next_st.fan_cnt > {1'b0, st.fan_dly}) next_st.fan = 1'b0; // R5
          end
        end
        `FAN_HOT: begin
          if (!hs_hot) begin
            next_st.fan     = 1'b0; // R7
            next_st.fan_cnt = 11'h000;
          end else begin
            if (st.tick && st.fan_cnt <= {1'b0, st.fan_dly})
              next_st.fan_cnt = st.fan_cnt + 11'h001;
            next_st.fan = (next_st.fan_cnt <= {1'b0, st.fan_dly}); // R7
          end
        end
        default: begin
          next_st.fan     = 1'b1; // R6
          next_st.fan_cnt = 11'h000;
        end
      endcase
    end

    // temperature relay with hysteresis; return level capped at reached
    retc = (st.ret > st.reach) ? st.reach : st.ret; // R14
    if (st.cfg.relay_fn != `RLY_FN) next_st.relay = 1'b0;
    else if (i_meas.temp > st.reach) next_st.relay = 1'b1; // R13
    else if (i_meas.temp <= retc) next_st.relay = 1'b0; // R14

    // stop requests; only ground fault still stops during fire mode
    next_st.coast = next_st.gf_f | (!fa & ((next_st.oh_f & st.cfg.oh_sel[1]) |
                    (next_st.ext_f & st.cfg.ext_sel == `EXT_CST) |
                    (safe & st.cfg.safe_cst))); // R1 R2 R4 R9 R15
    next_st.dec = !next_st.coast & !fa & ((next_st.oh_f & st.cfg.oh_sel == `OH_DEC) |
                  (next_st.ext_f & st.cfg.ext_sel == `EXT_DEC) |
                  (safe & !st.cfg.safe_cst)); // R2 R4 R9 R15
    next_st.fault = next_st.gf_f | next_st.oh_f |
                    (next_st.ext_f & st.cfg.ext_sel != `EXT_KEEP); // R1 R10
    next_st.code = next_st.gf_f ? `FC_GF : next_st.oh_f ? `FC_OH :
                   next_st.ext_f ? `FC_EXT : `FC_NONE; // R1 R10 R12
    next_st.swf  = i_sw_vld & !(fa & supp(i_sw_code)); // R16
    next_st.fa   = fa; // R15
    next_st.frev = fa & st.cfg.fire_rev; // R22
  end

  // ==========================================================
  // state register
  // synchronous reset; the fire latch leaves only through reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st        <= '0;
      st.fire   <= F_OFF;
      st.oh_dly <= `OHD_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign o_awready     = st.awrdy;
  assign o_wready      = st.wrdy;
  assign o_bvalid      = st.bvalid;
  assign o_bresp       = st.bresp;
  assign o_arready     = st.arrdy;
  assign o_rvalid      = st.rvalid;
  assign o_rdata       = st.rdata;
  assign o_rresp       = st.rresp;
  assign o_stop_dec    = st.dec;
  assign o_stop_coast  = st.coast;
  assign o_fault       = st.fault;
  assign o_code        = st.code;
  assign o_fan_on      = st.fan;
  assign o_temp_relay  = st.relay;
  assign o_sw_fault    = st.swf;
  assign o_fire_active = st.fa;
  assign o_fire_rev    = st.frev;
  assign o_fire_src    = st.cfg.spd_src; // R21
  assign o_fire_spd    = st.spd;
  assign o_di_ignore   = st.lock;
  assign o_param_lock  = st.lock;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_gf;
    st.cfg.gf_en && ({i_meas.leak, 1'b0} > {1'b0, i_meas.rated});
  endsequence
  property p_gf;
    s_gf |=> st.gf_f && st.coast && st.fault && st.code == `FC_GF;
  endproperty
  a_gf: assert property (p_gf) else $error("ground fault not tripped"); // R1

  property p_ext;
    (st.cfg.ext_run && !i_running && !st.ext_f) |=> !st.ext_f;
  endproperty
  a_ext: assert property (p_ext) else $error("ext fault seen while stopped"); // R3

  property p_fire;
    st.fa |-> !st.dec && (st.coast == st.gf_f);
  endproperty
  a_fire: assert property (p_fire) else $error("motor stopped in fire mode"); // R15

  property p_fan1;
    (st.cfg.fan_mode == 2'h1 && !st.cfg.big) [*2] |-> st.fan;
  endproperty
  a_fan1: assert property (p_fan1) else $error("fan off in permanent mode"); // R6

  property p_big;
    st.cfg.big |=> st.fan;
  endproperty
  a_big: assert property (p_big) else $error("fan off on large model"); // R8

  property p_relay;
    (st.cfg.relay_fn == `RLY_FN && i_meas.temp > st.reach) |=> st.relay;
  endproperty
  a_relay: assert property (p_relay) else $error("relay not closed"); // R13

  property p_rly_off;
    (i_meas.temp <= st.reach && i_meas.temp <= st.ret) |=> !st.relay;
  endproperty
  a_rly_off: assert property (p_rly_off) else $error("relay not opened"); // R14

  property p_ohclr;
    $fell(st.oh_f) |-> $past(i_meas.rt) < `R_RESET;
  endproperty
  a_ohclr: assert property (p_ohclr) else $error("overheat cleared too hot"); // R11

  property p_ohtrip;
    $rose(st.oh_f) |-> $past(i_meas.open) ||
      ($past(i_meas.rt) > `R_TRIP && $past(st.oh_cnt) >= $past(st.oh_dly));
  endproperty
  a_ohtrip: assert property (p_ohtrip) else $error("overheat tripped early"); // R10

  sequence s_wr;
    $rose(st.bvalid) && st.lock;
  endsequence
  property p_lock;
    s_wr |-> st.bresp == `R_ERR;
  endproperty
  a_lock: assert property (p_lock) else $error("write accepted under lock"); // R17

  property p_sw;
    (i_sw_vld && supp(i_sw_code) && fa) |=> !st.swf;
  endproperty
  a_sw: assert property (p_sw) else $error("fault passed in fire mode"); // R16
endmodule

// ===== tb/drive_terminals_model.sv
// far-side model: terminal contacts and the motor thermistor loop
// assumes the bench sets contact states and resistance by nba
`timescale 1ns/1ps
module drive_terminals_model
  import dpf_pkg::*;
(
  // contact states and resistance from the bench
  input  wire logic        i_ext,
  input  wire logic        i_safe,
  input  wire logic        i_fire,
  input  wire logic        i_nc,
  input  wire logic        i_lock,
  input  wire logic [15:0] i_rt,
  input  wire logic        i_open,
  // levels seen at the drive terminals
  output pins_t            o_pins,
  output logic [15:0]      o_rt,
  output logic             o_open
);
  // =========================================================
  // terminals
  // a normally closed contact reads low when it operates
  assign o_pins = '{i_ext, i_safe, i_fire ^ i_nc, i_lock};
  // an open loop reads as infinite resistance, never a stale value
  assign o_rt   = i_open ? 16'hFFFF : i_rt;
  assign o_open = i_open;
endmodule

// ===== tb/drive_protection_fire_mode_supervisor_tb.sv
// bench: drives the supervisor through its bus, terminals and measurements
// assumes the far-side model and a one-second tick shortened to 20 cycles
`timescale 1ns/1ps
`include "dpf_regs.svh"
module drive_protection_fire_mode_supervisor_tb;
  import dpf_pkg::*;
  // =========================================================
  // signals
  logic        i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 1;
  logic        i_arvalid = 0, i_rready = 1, i_running = 0, i_sw_vld = 0;
  logic        ext = 0, safe = 0, fire = 0, nc = 0, lock = 0, is_open = 0, g;
  logic [7:0]  i_awaddr = 0, i_araddr = 0, i_sw_code = 0, temp = 0, o_code, sc;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [3:0]  i_wstrb = 4'hF;
  logic [15:0] leak = 0, rated = 0, rt = 0, m_rt;
  logic [1:0]  o_bresp, o_rresp, o_fire_src;
  logic [13:0] o_fire_spd;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_stop_dec, m_open;
  logic        o_stop_coast, o_fault, o_fan_on, o_temp_relay, o_sw_fault;
  logic        o_fire_active, o_fire_rev, o_di_ignore, o_param_lock;
  pins_t       i_pins;
  meas_t       i_meas;
  int          fails = 0, comparisons = 0, n;
  integer      seed = 32'hDBB6;
  logic [7:0]  sup_tbl [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h19, 8'h1A, 8'h1C, 8'h2E,
                                8'h31, 8'h3A};
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  assign i_meas = '{leak, rated, m_rt, m_open, temp};
  drive_terminals_model i_drive_terminals_model (.i_ext(ext), .i_safe(safe), .i_fire(fire),
    .i_nc(nc), .i_lock(lock), .i_rt(rt), .i_open(is_open), .o_pins(i_pins), .o_rt(m_rt),
    .o_open(m_open));
  drive_protection_fire_mode_supervisor #(.SEC_CYC(20)) i_drive_protection_fire_mode_supervisor (
    .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_pins, .i_meas, .i_running, .i_sw_vld, .i_sw_code,
    .o_stop_dec, .o_stop_coast, .o_fault, .o_code, .o_fan_on, .o_temp_relay, .o_sw_fault,
    .o_fire_active, .o_fire_rev, .o_fire_src, .o_fire_spd, .o_di_ignore, .o_param_lock);
  // =========================================================
  // expectations, comparison, closing
  function automatic logic gf_exp(logic [15:0] l, logic [15:0] r);
    return {l, 1'b0} > {1'b0, r};
  endfunction
  function automatic logic sup(logic [7:0] c);
    sup = 0;
    foreach (sup_tbl[j]) if (sup_tbl[j] == c) sup = 1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang();
    fails++;
    end_sim();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // bus tasks hold each channel until its own ready edge
  // bready and rready stay high, so back-to-back calls never redrive them
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    for (int k = 0; !done; k++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      if (o_bvalid) begin
        chk("bresp", 32'(er), 32'(o_bresp));
        done = 1;
      end
      if (k > 60) hang();
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    i_arvalid <= 1;
    i_araddr <= a;
    for (int k = 0; !done; k++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
      if (o_rvalid) begin
        chk("rdata", ed, o_rdata);
        chk("rresp", 32'(er), 32'(o_rresp));
        done = 1;
      end
      if (k > 60) hang();
    end
  endtask
  // =========================================================
  // scenarios
  initial begin
    cyc(5);
    i_rst_n <= 1;
    cyc(1);
    axr(`A_CTRL, 0, `R_OK);
    axr(8'h1C, 0, `R_ERR);
    // ground fault: exactly half, one above, then random currents
    axw(`A_CTRL, 32'h1, `R_OK);
    for (int k = 0; k < 8; k++) begin
      rated <= (k < 2) ? 16'h03E8 : 16'($random(seed));
      leak <= (k < 2) ? 16'h01F4 + 16'(k) : 16'($random(seed));
      cyc(3);
      g = gf_exp(leak, rated);
      chk("gf", g ? 32'hF3 : 32'h0, 32'({o_code, o_stop_coast, o_fault}));
      leak <= 0;
      axw(`A_CLR, 1, `R_OK);
    end
    // overheat: the trip level itself never trips, one ohm above does
    axw(`A_CTRL, 32'h100, `R_OK);
    rt <= 16'h0532;
    cyc(60);
    chk("oh_hold", 0, 32'(o_fault));
    rt <= 16'h0533;
    for (n = 0; o_fault !== 1'b1; n++) begin
      cyc(1);
      if (n > 80) hang();
    end
    chk("oh", 32'hBB, 32'({o_code, o_stop_dec, o_fault}));
    rt <= 16'h03E8;
    axw(`A_CLR, 1, `R_OK);
    chk("oh_keep", 1, 32'(o_fault));
    rt <= 16'h0225;
    cyc(2);
    axw(`A_CLR, 1, `R_OK);
    cyc(1);
    chk("oh_clr", 0, 32'(o_fault));
    axw(`A_CTRL, 32'h200, `R_OK);
    is_open <= 1;
    cyc(3);
    chk("open", 32'hBB, 32'({o_code, o_stop_coast, o_fault}));
    is_open <= 0;
    cyc(2);
    axw(`A_CLR, 1, `R_OK);
    // fan with run state; relay return level capped at the reached level
    axw(`A_CTRL, 32'h3B0000, `R_OK);
    axw(`A_TEMP, 32'hC864, `R_OK);
    i_running <= 1;
    temp <= 8'h65;
    cyc(3);
    chk("run", 3, 32'({o_fan_on, o_temp_relay}));
    temp <= 8'h64;
    cyc(3);
    chk("ret", 2, 32'({o_fan_on, o_temp_relay}));
    i_running <= 0;
    cyc(30);
    chk("stop", 0, 32'(o_fan_on));
    axw(`A_CTRL, 32'h20, `R_OK);
    cyc(3);
    chk("perm", 1, 32'(o_fan_on));
    // hot mode follows the heatsink; a large model keeps the fan on when cool
    axw(`A_FAND, 32'hFFF, `R_OK);
    axr(`A_FAND, 32'h258, `R_OK);
    axw(`A_CTRL, 32'h40, `R_OK);
    temp <= 8'h5A;
    cyc(3);
    chk("cool", 0, 32'(o_fan_on));
    temp <= 8'h5B;
    cyc(3);
    chk("hot", 1, 32'(o_fan_on));
    axw(`A_CTRL, 32'hC0, `R_OK);
    temp <= 8'h5A;
    cyc(3);
    chk("big", 1, 32'(o_fan_on));
    // external fault coasts, but only while running
    axw(`A_CTRL, 32'hA, `R_OK);
    ext <= 1;
    cyc(4);
    chk("ext_idle", 0, 32'({o_code, o_stop_coast}));
    i_running <= 1;
    cyc(4);
    chk("ext", 32'h7B, 32'({o_code, o_stop_coast}));
    ext <= 0;
    i_running <= 0;
    axw(`A_CLR, 1, `R_OK);
    // polarity changed only while fire mode is off
    nc <= 1;
    axw(`A_CTRL, 32'h1000, `R_OK);
    safe <= 1;
    cyc(4);
    chk("safe", 2, 32'({o_stop_dec, o_stop_coast}));
    axw(`A_CTRL, 32'hDC00, `R_OK);
    axw(`A_FSPD, 32'h2EE0, `R_OK);
    cyc(4);
    chk("idle", 0, 32'(o_fire_active));
    fire <= 1;
    cyc(4);
    chk("fire", 32'hCA710, 32'({o_fire_active, o_fire_rev, o_stop_dec, o_stop_coast,
      o_fire_src, o_fire_spd}));
    // every listed code once, random codes between them
    for (int k = 0; k < 20; k++) begin
      sc = k[0] ? 8'($random(seed)) : sup_tbl[k / 2];
      i_sw_code <= sc;
      i_sw_vld <= 1;
      cyc(3);
      chk("sw", 32'(!sup(sc)), 32'(o_sw_fault));
    end
    lock <= 1;
    cyc(4);
    chk("lock", 3, 32'({o_di_ignore, o_param_lock}));
    axw(`A_CTRL, 32'h0, `R_ERR);
    axr(`A_CTRL, 32'hDC00, `R_OK);
    lock <= 0;
    fire <= 0;
    i_sw_code <= 8'h04;
    cyc(4);
    chk("exit", 0, 32'(o_fire_active));
    chk("sw_idle", 1, 32'(o_sw_fault));
    // a latched fire mode ignores trigger removal and leaves only through reset
    axw(`A_CTRL, 32'h1400, `R_OK);
    fire <= 1;
    cyc(4);
    fire <= 0;
    cyc(6);
    chk("latch", 2, 32'({o_fire_active, o_fire_rev}));
    i_rst_n <= 0;
    cyc(2);
    i_rst_n <= 1;
    cyc(2);
    chk("power", 0, 32'(o_fire_active));
    end_sim();
  end
endmodule
